/* File: hw/idac_update_control.sv */
// Update control for a 10-bit current DAC: data byte registers, update source and range.
// Assumes timer overflow pulses come from logic on mclk; convert start is an async pin.
//
// Contract
// - Source codes 000 to 011 hold data writes until an overflow of timer 0 to 3 copies the word.
// - Source codes 100, 101 and 110 hold data writes until the chosen convert start edge.
// - On that edge both data bytes are loaded together into the DAC input latches.
// - The word is left-justified: upper byte is bits 9 to 2, lower bits 7 and 6 are bits 1 and 0.
// - Range 1x gives 2 mA, 01 gives 1 mA and 00 gives 0.5 mA full scale.
// - After reset the range selects 2 mA until software changes it.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`default_nettype none
module idac_update_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [idac_update_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Update triggers
  input wire logic [3:0] timer_overflow,
  input wire logic convert_start_input,
  // Analog stage
  output var idac_update_pkg::dac_drive_t dac_drive,
  output logic dac_update
);
  logic [7:0] control_ff;
  logic [7:0] upper_ff;
  logic [7:0] lower_ff;
  logic [9:0] word_ff;
  logic [7:0] rdata_ff;
  logic [2:0] cs_sync_ff;
  logic [2:0] cs_armed_ff;
  logic update_ff;
  logic [2:0] src;
  logic [1:0] rng;
  logic rise;
  logic fall;
  logic nxt_update;
  idac_update_pkg::fullscale_t fs_ff;
  idac_update_pkg::fullscale_t nxt_fs;

  assign src = control_ff[idac_update_pkg::SRC_MSB:idac_update_pkg::SRC_LSB];
  assign rng = control_ff[idac_update_pkg::RNG_MSB:idac_update_pkg::RNG_LSB];

  // Bits outside the source and range fields are plain read/write storage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      control_ff <= idac_update_pkg::CONTROL_RESET;
    end else if (reg_wr && reg_addr == idac_update_pkg::OFF_CONTROL) begin
      control_ff <= reg_wdata;
    end
  end

  // Data bytes take every write; only a trigger moves them into the latch word
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      upper_ff <= idac_update_pkg::BYTE_RESET;
      lower_ff <= idac_update_pkg::BYTE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == idac_update_pkg::OFF_UPPER) begin
        upper_ff <= reg_wdata;
      end
      if (reg_addr == idac_update_pkg::OFF_LOWER) begin
        lower_ff <= reg_wdata;
      end
    end
  end

  // Third stage only feeds the edge detect; stage 0 is read by stage 1 alone
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cs_sync_ff <= 3'h0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], convert_start_input};
    end
  end
  // Edges stay masked until the chain holds real pin samples, so a pin that
  // idles high gives no false rising edge right after reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cs_armed_ff <= 3'h0;
    end else begin
      cs_armed_ff <= {cs_armed_ff[1:0], 1'b1};
    end
  end
  assign rise = cs_armed_ff[2] && cs_sync_ff[1] && !cs_sync_ff[2];
  assign fall = cs_armed_ff[2] && !cs_sync_ff[1] && cs_sync_ff[2];

  always_comb begin
    nxt_update = 1'b0;
    if (src <= idac_update_pkg::SRC_TMR3) begin
      nxt_update = timer_overflow[src[1:0]];
    end else if (src == idac_update_pkg::SRC_RISE) begin
      nxt_update = rise;
    end else if (src == idac_update_pkg::SRC_FALL) begin
      nxt_update = fall;
    end else if (src == idac_update_pkg::SRC_BOTH) begin
      nxt_update = rise || fall;
    end
  end

  // Code 111 never updates; the latches keep their word
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      word_ff <= idac_update_pkg::WORD_RESET;
      update_ff <= 1'b0;
    end else begin
      update_ff <= nxt_update;
      if (nxt_update) begin
        word_ff <= {upper_ff, lower_ff[7:idac_update_pkg::LOW_LSB]};
      end
    end
  end

  // Range 11 also gives 2 mA, so the top bit alone picks it
  always_comb begin
    nxt_fs = '0;
    if (rng[1]) begin
      nxt_fs.sel_2ma = 1'b1;
    end else if (rng == idac_update_pkg::RNG_1MA) begin
      nxt_fs.sel_1ma = 1'b1;
    end else begin
      nxt_fs.sel_half = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fs_ff <= '{sel_2ma: 1'b1, sel_1ma: 1'b0, sel_half: 1'b0};
    end else begin
      fs_ff <= nxt_fs;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        idac_update_pkg::OFF_CONTROL: rdata_ff <= control_ff;
        idac_update_pkg::OFF_UPPER: rdata_ff <= upper_ff;
        idac_update_pkg::OFF_LOWER: rdata_ff <= lower_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;
  assign dac_drive = '{word: word_ff, fullscale: fs_ff};
  assign dac_update = update_ff;

  // Trigger decode and the latch word
  a_timer_copy: assert property (@(posedge mclk) disable iff (!rstn)
    (src <= idac_update_pkg::SRC_TMR3 && timer_overflow[src[1:0]]) |=> (dac_update &&
      word_ff == {$past(upper_ff), $past(lower_ff[7:idac_update_pkg::LOW_LSB])}))
    else $error("timer overflow did not copy word");
  a_timer_other: assert property (@(posedge mclk) disable iff (!rstn)
    (src <= idac_update_pkg::SRC_TMR3 && !timer_overflow[src[1:0]]) |=> !dac_update)
    else $error("update without selected timer overflow");
  a_hold_writes: assert property (@(posedge mclk) disable iff (!rstn)
    !dac_update |-> $stable(word_ff))
    else $error("dac word changed without update");
  a_edge_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    (src >= idac_update_pkg::SRC_RISE && cs_sync_ff[1] == cs_sync_ff[2]) |=> !dac_update)
    else $error("pin source updated without an edge");
  a_idle_source: assert property (@(posedge mclk) disable iff (!rstn)
    (&src) |=> !dac_update)
    else $error("idle source code updated the word");
  a_rise_update: assert property (@(posedge mclk) disable iff (!rstn)
    (src == idac_update_pkg::SRC_RISE && cs_armed_ff[2] && cs_sync_ff[1] && !cs_sync_ff[2])
      |=> dac_update)
    else $error("rising edge missed");
  a_fall_update: assert property (@(posedge mclk) disable iff (!rstn)
    (src == idac_update_pkg::SRC_FALL && cs_armed_ff[2] && !cs_sync_ff[1] && cs_sync_ff[2])
      |=> dac_update)
    else $error("falling edge missed");
  a_both_update: assert property (@(posedge mclk) disable iff (!rstn)
    (src == idac_update_pkg::SRC_BOTH && cs_armed_ff[2] && cs_sync_ff[1] != cs_sync_ff[2])
      |=> dac_update)
    else $error("edge missed in both-edge mode");
  a_edge_load: assert property (@(posedge mclk) disable iff (!rstn)
    dac_update |-> word_ff[9:2] == $past(upper_ff))
    else $error("upper byte not loaded");
  a_left_justify: assert property (@(posedge mclk) disable iff (!rstn)
    dac_update |-> word_ff[1:0] == $past(lower_ff[7:idac_update_pkg::LOW_LSB]))
    else $error("lower bits misplaced");
  a_reset_word: assert property (@(posedge mclk)
    !rstn |=> (dac_drive.word == idac_update_pkg::WORD_RESET && !dac_update))
    else $error("word or update pulse not cleared by reset");

  // Full-scale range
  a_range_map: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 (fs_ff.sel_2ma == $past(rng[1]) &&
      fs_ff.sel_half == ($past(rng) == idac_update_pkg::RNG_HALF)))
    else $error("full scale mismatch");
  a_one_ma: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 (fs_ff.sel_1ma == ($past(rng) == idac_update_pkg::RNG_1MA)))
    else $error("1 mA select mismatch");
  a_fs_onehot: assert property (@(posedge mclk) disable iff (!rstn)
    $onehot(fs_ff))
    else $error("full scale select not one-hot");
  a_reset_range: assert property (@(posedge mclk)
    !rstn |=> (fs_ff.sel_2ma && rng == idac_update_pkg::RNG_2MA))
    else $error("range not 2 mA after reset");

  // Register read port
  a_read_upper: assert property (@(posedge mclk) disable iff (!rstn)
    (reg_rd && reg_addr == idac_update_pkg::OFF_UPPER) |=> reg_rdata == $past(upper_ff))
    else $error("upper byte read back wrong");
  a_read_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !reg_rd |=> reg_rdata == idac_update_pkg::BYTE_RESET)
    else $error("read data not zero outside a read");

  c_timer: cover property (@(posedge mclk) disable iff (!rstn)
    src == idac_update_pkg::SRC_TMR0 ##1 dac_update);
  c_fall: cover property (@(posedge mclk) disable iff (!rstn)
    src == idac_update_pkg::SRC_FALL ##1 dac_update);
  c_both: cover property (@(posedge mclk) disable iff (!rstn)
    src == idac_update_pkg::SRC_BOTH ##1 dac_update);
  c_half: cover property (@(posedge mclk) disable iff (!rstn) fs_ff.sel_half);
  c_one_ma: cover property (@(posedge mclk) disable iff (!rstn) fs_ff.sel_1ma);
endmodule // idac_update_control
`default_nettype wire

/* File: hw/idac_update_pkg.sv */
// Constants, register map and carriers for the current DAC update control.
// Assumes a plain byte-wide register port on a single system clock.
`default_nettype none
package idac_update_pkg;
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFF_CONTROL = 2'h0;
  localparam logic [1:0] OFF_UPPER = 2'h1;
  localparam logic [1:0] OFF_LOWER = 2'h2;
  localparam int SRC_LSB = 4;
  localparam int SRC_MSB = 6;
  localparam int RNG_LSB = 0;
  localparam int RNG_MSB = 1;
  localparam int LOW_LSB = 6;
  localparam logic [2:0] SRC_TMR0 = 3'h0;
  localparam logic [2:0] SRC_TMR3 = 3'h3;
  localparam logic [2:0] SRC_RISE = 3'h4;
  localparam logic [2:0] SRC_FALL = 3'h5;
  localparam logic [2:0] SRC_BOTH = 3'h6;
  localparam logic [1:0] RNG_2MA = 2'h2;
  localparam logic [1:0] RNG_1MA = 2'h1;
  localparam logic [1:0] RNG_HALF = 2'h0;
  localparam logic [7:0] CONTROL_RESET = 8'h72;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [9:0] WORD_RESET = 10'h000;
  // One-hot full-scale drive to the analog stage
  typedef struct packed {
    logic sel_2ma;
    logic sel_1ma;
    logic sel_half;
  } fullscale_t;
  typedef struct packed {
    logic [9:0] word;
    fullscale_t fullscale;
  } dac_drive_t;
endpackage
`default_nettype wire

/* File: test/idac_latch_model.sv */
// Far-side model: DAC input latches that load the word on each update pulse.
// Assumes drive and pulse are launched from mclk by the control block.
`default_nettype none
module idac_latch_model (
  // Clock, drive from the control block, word held by the output stage
  input wire logic mclk,
  input wire idac_update_pkg::dac_drive_t dac_drive,
  input wire logic dac_update,
  output var logic [9:0] latched
);
  always_ff @(posedge mclk) if (dac_update) latched <= dac_drive.word;
endmodule // idac_latch_model
`default_nettype wire

/* File: test/tb.sv */
// Bench for the current DAC update control: registers, timer and pin triggers.
// Assumes the design package and the latch model are compiled before it.
`default_nettype none
module tb;
  timeunit 1ns / 1ps;
  logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, convert_start_input = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [3:0] timer_overflow = 4'h0;
  logic [9:0] latched, w = 10'h000;
  logic dac_update;
  idac_update_pkg::dac_drive_t dac_drive;
  int fail_count = 0, compares = 0;
  initial forever #4 mclk = ~mclk;
  idac_update_control dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_overflow(timer_overflow), .convert_start_input(convert_start_input),
    .dac_drive(dac_drive), .dac_update(dac_update));
  idac_latch_model far (.mclk(mclk), .dac_drive(dac_drive), .dac_update(dac_update),
    .latched(latched));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    fail_count += int'(got !== exp);
  endtask
  task automatic results();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // A read expects d in the one cycle after the strobe
  task automatic bus(input logic w_en, input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata} <= {a, d};
    {reg_wr, reg_rd} <= {w_en, !w_en};
    @(posedge mclk);
    {reg_wr, reg_rd} <= 2'h0;
    #1 if (!w_en) check(16'(reg_rdata), 16'(d));
  endtask
  // Window of nine cycles covers both the timer and the synchronised pin path
  task automatic fire(input logic [3:0] t, input logic p, input logic e);
    logic seen = 1'b0;
    @(posedge mclk);
    {timer_overflow, convert_start_input} <= {t, p};
    repeat (9) begin
      @(posedge mclk);
      timer_overflow <= 4'h0;
      #1 seen = seen | (dac_update === 1'b1);
    end
    check(16'(seen), 16'(e));
    if (e && !seen) results();
    check(16'(dac_drive.word), 16'(w));
    if (seen) check(16'(latched), 16'(w));
  endtask
  task automatic t_regs();
    bus(1'b0, 2'h0, 8'h72);
    check(16'(dac_drive.fullscale), 16'h0004);
    bus(1'b0, 2'h3, 8'h00);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 2'h0, 8'(8'h70 + r));
      bus(1'b0, 2'h0, 8'(8'h70 + r));
      check(16'(dac_drive.fullscale), 16'(r > 1 ? 4 : (r == 1 ? 2 : 1)));
    end
    bus(1'b1, 2'h3, 8'hFF);
    bus(1'b0, 2'h0, 8'h73);
    fire(4'hF, 1'b1, 1'b0);
    fire(4'h0, 1'b0, 1'b0);
    $display("regs done");
  endtask
  task automatic t_timer();
    bus(1'b1, 2'h2, 8'hBF);
    bus(1'b0, 2'h2, 8'hBF);
    for (int n = 0; n < 4; n++) begin
      bus(1'b1, 2'h0, 8'(n * 16 + 2));
      bus(1'b1, 2'h1, 8'(8'hA0 + n));
      bus(1'b0, 2'h1, 8'(8'hA0 + n));
      fire(4'(1 << ((n + 1) % 4)), 1'b0, 1'b0);
      w = {8'(8'hA0 + n), 2'h2};
      fire(4'(1 << n), 1'b0, 1'b1);
    end
    $display("timer done");
  endtask
  task automatic t_edge();
    for (int c = 4; c < 7; c++) begin
      bus(1'b1, 2'h0, 8'(c * 16 + 1));
      bus(1'b1, 2'h1, 8'(c * 17));
      bus(1'b1, 2'h2, 8'((c - 3) * 64));
      if (c != 5) w = {8'(c * 17), 2'(c - 3)};
      fire(4'h0, 1'b1, c != 5);
      w = {8'(c * 17), 2'(c - 3)};
      fire(4'h0, 1'b0, c != 4);
    end
    $display("edge done");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_timer();
    t_edge();
    results();
  end
endmodule // tb
`default_nettype wire
